// ===== rtl/aux_cfg_pkg.sv
// package with register map, field layout, reset values and types of the aux config bank
// What this block does
// - slot input selector picks sampled input; 0111 auto-zero, 1xxx temperature
// - slot input selector resets to temperature code 1000
// - slot converter-disable bit 3 skips the conversion of that slot
// - gain field codes 000..101 give gains 1,2,4,8,16,32
// - harmonic order bits 12:8, orders 1..21; results at 0x830 and 0x840
// - bit 7 routes aux channel through harmonic filter with its coefficients
// - aux processing runs only while bit 6 is set
// - bit 5 set subtracts neutral current in vector sum, clear adds it
// - selector bit 3 clear picks one input; set picks vector sum 1001/1111
// - single codes 0001 In, 0010 Va, 0101 Ib, 0110 Vc, 0111 Ic; rest reserved
// - aux channel rms is computed only while the aux channel runs, beside normal processing
// - clock frequency register in kHz resets to 0x1f40 for 8 MHz
// - after programmed line cycles accumulate, run power, pf and energy
// - line cycle count resets to 16
package aux_cfg_pkg;
  localparam logic [11:0] temp_slot_addr = 12'h00f;
  localparam logic [11:0] aux_cfg_addr = 12'h010;
  localparam logic [11:0] sys_clk_addr = 12'h012;
  localparam logic [11:0] cyc_cnt_addr = 12'h01c;
  localparam logic [11:0] harm_v_addr = 12'h830;
  localparam logic [11:0] harm_i_addr = 12'h840;
  localparam logic [7:0] temp_slot_reset = 8'h8a;
  localparam logic [15:0] aux_cfg_reset = 16'h0000;
  localparam logic [15:0] aux_cfg_wmask = 16'h1fef;
  localparam logic [15:0] sys_clk_reset = 16'h1f40;
  localparam logic [15:0] cyc_cnt_reset = 16'h0010;
  localparam int slot_disable_bit = 3;
  localparam int harm_enable_bit = 7;
  localparam int aux_enable_bit = 6;
  localparam int neutral_sign_bit = 5;
  localparam int vector_sel_bit = 3;
  localparam logic [4:0] harm_order_min = 5'h01;
  localparam logic [4:0] harm_order_max = 5'h15;
  localparam logic [2:0] gain_code_max = 3'h5;
  localparam logic [3:0] sel_in = 4'h1;
  localparam logic [3:0] sel_va = 4'h2;
  localparam logic [3:0] sel_ib = 4'h5;
  localparam logic [3:0] sel_vc = 4'h6;
  localparam logic [3:0] sel_ic = 4'h7;
  localparam logic [3:0] sel_sum3 = 4'h9;
  localparam logic [3:0] sel_sum4 = 4'hf;
  localparam logic [3:0] slot_auto_zero = 4'h7;
  typedef enum logic [3:0] {
    src_none = 4'h0,
    src_in = 4'h1,
    src_va = 4'h2,
    src_ib = 4'h3,
    src_vc = 4'h4,
    src_ic = 4'h5,
    src_sum3 = 4'h6,
    src_sum4 = 4'h7
  } aux_src_t;
  typedef struct packed {
    logic [3:0] input_select;
    logic converter_disable;
    logic [2:0] gain_select;
  } slot_cfg_t;
  typedef struct packed {
    logic [4:0] harmonic_order;
    logic harmonic_filter_enable;
    logic channel_enable;
    logic neutral_sign_invert;
    logic [3:0] input_select;
  } aux_cfg_t;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [11:0] addr;
    logic [15:0] wdata;
  } reg_req_t;
  typedef struct packed {
    logic temp_sel;
    logic auto_zero;
    logic [2:0] analog_sel;
    logic skip;
    logic [5:0] gain;
  } slot_ctl_t;
endpackage : aux_cfg_pkg

// ===== rtl/aux_src_decode.sv
// combinational decode of the aux selector into a source and sign
`timescale 1ns/1ps
`default_nettype none
module aux_src_decode (
  input wire logic [3:0] sel_in,
  input wire logic neutral_invert_in,
  output aux_cfg_pkg::aux_src_t src_out,
  output logic neutral_sub_out,
  output logic reserved_out
);
  import aux_cfg_pkg::*;
  always_comb begin
    src_out = src_none;
    reserved_out = 1'b0;
    neutral_sub_out = 1'b0;
    if (sel_in[vector_sel_bit]) begin
      // vector sum forms
      if (sel_in == sel_sum3) begin
        src_out = src_sum3;
      end else if (sel_in == sel_sum4) begin
        src_out = src_sum4;
        neutral_sub_out = neutral_invert_in;
      end else begin
        reserved_out = 1'b1;
      end
    end else begin
      // ambiguous phase b voltage code left reserved
      unique case (sel_in)
        // package code named in full; the port of the same name would hide it
        aux_cfg_pkg::sel_in: src_out = src_in;
        sel_va: src_out = src_va;
        sel_ib: src_out = src_ib;
        sel_vc: src_out = src_vc;
        sel_ic: src_out = src_ic;
        default: reserved_out = 1'b1;
      endcase
    end
  end
endmodule : aux_src_decode
`default_nettype wire

// ===== rtl/aux_cfg_bank.sv
// register bank for temperature slot, aux channel, clock frequency and cycle count
`timescale 1ns/1ps
`default_nettype none
module aux_cfg_bank (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire aux_cfg_pkg::reg_req_t host_req_in,
  input wire aux_cfg_pkg::reg_req_t fw_req_in,
  input wire logic line_cycle_in,
  input wire logic [15:0] harm_v_result_in,
  input wire logic [15:0] harm_i_result_in,
  output logic [15:0] rdata_out,
  output logic rvalid_out,
  output aux_cfg_pkg::slot_ctl_t temp_slot_ctl_out,
  output aux_cfg_pkg::aux_src_t aux_src_out,
  output logic aux_neutral_sub_out,
  output logic aux_run_out,
  output logic aux_harm_filter_out,
  output logic aux_rms_run_out,
  output logic [4:0] harm_order_out,
  output logic harm_order_valid_out,
  output logic [15:0] sys_clk_khz_out,
  output logic dsp_calc_out
);
  import aux_cfg_pkg::*;

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic rst_sync1_r;
  logic rst_sync2_r;
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_sync1_r <= 1'b0;
      rst_sync2_r <= 1'b0;
    end else begin
      rst_sync1_r <= 1'b1;
      rst_sync2_r <= rst_sync1_r;
    end
  end
  logic rst_n;
  assign rst_n = rst_sync2_r;

  // ----------------------------------------
  // register storage
  // ----------------------------------------
  slot_cfg_t temp_slot_r;
  slot_cfg_t temp_slot_nxt;
  logic [15:0] aux_cfg_r;
  logic [15:0] aux_cfg_nxt;
  logic [15:0] sys_clk_r;
  logic [15:0] sys_clk_nxt;
  logic [15:0] cyc_cnt_r;
  logic [15:0] cyc_cnt_nxt;
  reg_req_t req;
  logic [5:0] hit;

  // host wins a same-cycle collision; firmware retries on its own schedule
  always_comb begin
    req = fw_req_in;
    if (host_req_in.wr || host_req_in.rd) begin
      req = host_req_in;
    end
  end

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  // one map for both paths, so a read can never disagree with a write
  function automatic logic [5:0] reg_hit(input logic [11:0] addr);
    reg_hit = 6'h00;
    unique case (addr)
      temp_slot_addr: reg_hit = 6'h01;
      aux_cfg_addr: reg_hit = 6'h02;
      sys_clk_addr: reg_hit = 6'h04;
      cyc_cnt_addr: reg_hit = 6'h08;
      harm_v_addr: reg_hit = 6'h10;
      harm_i_addr: reg_hit = 6'h20;
      default: reg_hit = 6'h00;
    endcase
  endfunction : reg_hit
  assign hit = reg_hit(req.addr);

  always_comb begin
    temp_slot_nxt = temp_slot_r;
    aux_cfg_nxt = aux_cfg_r;
    sys_clk_nxt = sys_clk_r;
    cyc_cnt_nxt = cyc_cnt_r;
    if (req.wr) begin
      // host writes are accepted; keeping off this one is up to the host
      if (hit[0]) begin
        temp_slot_nxt = slot_cfg_t'(req.wdata[7:0]);
      end
      if (hit[1]) begin
        aux_cfg_nxt = req.wdata & aux_cfg_wmask;
      end
      if (hit[2]) begin
        sys_clk_nxt = req.wdata;
      end
      if (hit[3]) begin
        cyc_cnt_nxt = req.wdata;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      temp_slot_r <= slot_cfg_t'(temp_slot_reset);
      aux_cfg_r <= aux_cfg_reset;
      sys_clk_r <= sys_clk_reset;
      cyc_cnt_r <= cyc_cnt_reset;
    end else begin
      temp_slot_r <= temp_slot_nxt;
      aux_cfg_r <= aux_cfg_nxt;
      sys_clk_r <= sys_clk_nxt;
      cyc_cnt_r <= cyc_cnt_nxt;
    end
  end

  // ----------------------------------------
  // read path
  // ----------------------------------------
  logic [15:0] rdata_nxt;
  logic [15:0] rdata_r;
  logic rvalid_nxt;
  logic rvalid_r;
  always_comb begin
    // read data holds between reads; unmapped reads return zero
    rdata_nxt = rdata_r;
    rvalid_nxt = req.rd;
    if (req.rd) begin
      rdata_nxt = 16'h0000;
      if (hit[0]) begin
        rdata_nxt = {8'h00, temp_slot_r};
      end
      if (hit[1]) begin
        rdata_nxt = aux_cfg_r & aux_cfg_wmask;
      end
      if (hit[2]) begin
        rdata_nxt = sys_clk_r;
      end
      if (hit[3]) begin
        rdata_nxt = cyc_cnt_r;
      end
      if (hit[4]) begin
        rdata_nxt = harm_v_result_in;
      end
      if (hit[5]) begin
        rdata_nxt = harm_i_result_in;
      end
    end
  end
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= 16'h0000;
      rvalid_r <= 1'b0;
    end else begin
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end
  assign rdata_out = rdata_r;
  assign rvalid_out = rvalid_r;

  // ----------------------------------------
  // temperature slot control
  // ----------------------------------------
  function automatic logic [5:0] gain_onehot(input logic [2:0] code);
    // reserved codes give no gain bit at all
    gain_onehot = (code <= gain_code_max) ? 6'(6'h01 << code) : 6'h00;
  endfunction : gain_onehot

  slot_ctl_t slot_ctl_nxt;
  slot_ctl_t slot_ctl_r;
  always_comb begin
    slot_ctl_nxt.temp_sel = temp_slot_r.input_select[3];
    slot_ctl_nxt.auto_zero = (temp_slot_r.input_select == slot_auto_zero);
    slot_ctl_nxt.analog_sel = temp_slot_r.input_select[2:0];
    slot_ctl_nxt.skip = temp_slot_r[slot_disable_bit];
    slot_ctl_nxt.gain = gain_onehot(temp_slot_r.gain_select);
  end
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      slot_ctl_r <= '0;
    end else begin
      slot_ctl_r <= slot_ctl_nxt;
    end
  end
  assign temp_slot_ctl_out = slot_ctl_r;

  // ----------------------------------------
  // aux channel control
  // ----------------------------------------
  aux_cfg_t aux_view;
  aux_src_t dec_src;
  logic dec_sub;
  logic dec_reserved;
  assign aux_view = {aux_cfg_r[12:5], aux_cfg_r[3:0]};

  aux_src_decode u_dec (
    .sel_in(aux_view.input_select),
    .neutral_invert_in(aux_view.neutral_sign_invert),
    .src_out(dec_src),
    .neutral_sub_out(dec_sub),
    .reserved_out(dec_reserved)
  );

  aux_src_t src_r;
  aux_src_t src_nxt;
  logic sub_r;
  logic sub_nxt;
  logic run_r;
  logic run_nxt;
  logic harm_r;
  logic harm_nxt;
  logic rms_r;
  logic rms_nxt;
  logic [4:0] order_r;
  logic [4:0] order_nxt;
  logic order_ok_r;
  logic order_ok_nxt;
  always_comb begin
    // reserved selector halts the channel rather than feed it garbage
    run_nxt = aux_cfg_r[aux_enable_bit] && !dec_reserved;
    src_nxt = run_nxt ? dec_src : src_none;
    sub_nxt = run_nxt && dec_sub;
    harm_nxt = run_nxt && aux_cfg_r[harm_enable_bit];
    rms_nxt = run_nxt;
    order_nxt = aux_view.harmonic_order;
    order_ok_nxt = (aux_view.harmonic_order >= harm_order_min)
      && (aux_view.harmonic_order <= harm_order_max);
  end
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      src_r <= src_none;
      sub_r <= 1'b0;
      run_r <= 1'b0;
      harm_r <= 1'b0;
      rms_r <= 1'b0;
      order_r <= 5'h00;
      order_ok_r <= 1'b0;
    end else begin
      src_r <= src_nxt;
      sub_r <= sub_nxt;
      run_r <= run_nxt;
      harm_r <= harm_nxt;
      rms_r <= rms_nxt;
      order_r <= order_nxt;
      order_ok_r <= order_ok_nxt;
    end
  end
  assign aux_src_out = src_r;
  assign aux_neutral_sub_out = sub_r;
  assign aux_run_out = run_r;
  assign aux_harm_filter_out = harm_r;
  assign aux_rms_run_out = rms_r;
  assign harm_order_out = order_r;
  assign harm_order_valid_out = order_ok_r;

  // ----------------------------------------
  // clock frequency out
  // ----------------------------------------
  logic [15:0] clk_out_r;
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      clk_out_r <= sys_clk_reset;
    end else begin
      clk_out_r <= sys_clk_r;
    end
  end
  assign sys_clk_khz_out = clk_out_r;

  // ----------------------------------------
  // line cycle accumulation
  // ----------------------------------------
  // one step for compare and update, so the two cannot drift apart
  function automatic logic [15:0] count_up(input logic [15:0] v);
    count_up = v + 16'h0001;
  endfunction : count_up

  logic [15:0] line_cnt_r;
  logic [15:0] line_cnt_nxt;
  logic calc_r;
  logic calc_nxt;
  always_comb begin
    line_cnt_nxt = line_cnt_r;
    calc_nxt = 1'b0;
    if (line_cycle_in) begin
      // a count of zero behaves as one so calculations never stall
      if (count_up(line_cnt_r) >= cyc_cnt_r) begin
        line_cnt_nxt = 16'h0000;
        calc_nxt = 1'b1;
      end else begin
        line_cnt_nxt = count_up(line_cnt_r);
      end
    end
  end
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      line_cnt_r <= 16'h0000;
      calc_r <= 1'b0;
    end else begin
      line_cnt_r <= line_cnt_nxt;
      calc_r <= calc_nxt;
    end
  end
  assign dsp_calc_out = calc_r;
endmodule : aux_cfg_bank
`default_nettype wire

// ===== testbench/host_master_model.sv
// host master model driving the register request port of the aux config bank
`timescale 1ns/1ps
`default_nettype none
module host_master_model (
  input wire logic core_clk_in,
  input wire logic rvalid_in,
  input wire logic [15:0] rdata_in,
  output var aux_cfg_pkg::reg_req_t host_req_out
);
  import aux_cfg_pkg::*;
  initial host_req_out = '0;
  // ------------------------------------------------
  // request tasks
  // ------------------------------------------------
  // never writes gain codes above 5 or the firmware-owned slot
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    @(negedge core_clk_in);
    host_req_out = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge core_clk_in);
    // released lines must not keep their last value
    host_req_out = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [15:0] d);
    logic ok;
    @(negedge core_clk_in);
    host_req_out = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(negedge core_clk_in);
    host_req_out = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 16'hffff};
    ok = 1'b0;
    d = 'x;
    // the answer stands one cycle only, so look first on this very falling edge
    for (int i = 0; i < 3 && !ok; i++) begin
      if (i > 0) begin
        @(negedge core_clk_in);
      end
      if (rvalid_in === 1'b1) begin
        ok = 1'b1;
        d = rdata_in;
      end
    end
  endtask : rd
endmodule : host_master_model
`default_nettype wire

// ===== testbench/aux_cfg_bank_monitor.sv
// concurrent checks on the ports of the aux config bank
`timescale 1ns/1ps
`default_nettype none
module aux_cfg_bank_monitor (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire aux_cfg_pkg::reg_req_t host_req_in,
  input wire aux_cfg_pkg::reg_req_t fw_req_in,
  input wire logic line_cycle_in,
  input wire logic [15:0] rdata_out,
  input wire logic rvalid_out,
  input wire aux_cfg_pkg::slot_ctl_t temp_slot_ctl_out,
  input wire aux_cfg_pkg::aux_src_t aux_src_out,
  input wire logic aux_neutral_sub_out,
  input wire logic aux_run_out,
  input wire logic aux_harm_filter_out,
  input wire logic aux_rms_run_out,
  input wire logic [4:0] harm_order_out,
  input wire logic [15:0] sys_clk_khz_out,
  input wire logic dsp_calc_out
);
  import aux_cfg_pkg::*;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  wire logic [15:0] hd = host_req_in.wdata;
  wire logic [15:0] fd = fw_req_in.wdata;
  wire logic hw = host_req_in.wr | host_req_in.rd;
  wire logic aw = host_req_in.wr && host_req_in.addr == aux_cfg_addr;
  wire logic ar = host_req_in.rd && host_req_in.addr == aux_cfg_addr;
  wire logic cw = host_req_in.wr && host_req_in.addr == sys_clk_addr;
  // firmware only lands when the host is idle
  wire logic tw = fw_req_in.wr && !hw && fw_req_in.addr == temp_slot_addr;
  a_slot_pick: assert property (
    tw |-> ##2 temp_slot_ctl_out.temp_sel == $past(fd[7], 2)
      && temp_slot_ctl_out.auto_zero == ($past(fd[7:4], 2) == slot_auto_zero))
    else $error("slot input select decode wrong");
  a_slot_skip: assert property (
    tw |-> ##2 temp_slot_ctl_out.skip == $past(fd[3], 2)) else $error("slot skip wrong");
  a_gain_onehot: assert property (
    tw && fd[2:0] <= gain_code_max |-> ##2 temp_slot_ctl_out.gain == 6'(6'h01 << $past(fd[2:0], 2)))
    else $error("gain decode wrong");
  a_harm_order: assert property (
    aw |-> ##2 harm_order_out == $past(hd[12:8], 2)) else $error("harmonic order wrong");
  a_harm_filter: assert property (
    aw |-> ##2 aux_harm_filter_out == (aux_run_out && $past(hd[7], 2)))
    else $error("harmonic filter gate wrong");
  a_aux_run_gate: assert property (
    aw && !hd[6] |-> ##2 !aux_run_out [*2]) else $error("aux runs while disabled");
  a_neutral_sign: assert property (
    aw |-> ##2 aux_neutral_sub_out == $past(hd[6] && hd[5] && hd[3:0] == sel_sum4, 2))
    else $error("neutral sign wrong");
  a_sum_select: assert property (
    aw && hd[6] && hd[3:0] == sel_sum3 |-> ##2 aux_src_out == src_sum3) else $error("sum3 wrong");
  a_rms_follow: assert property (
    aux_rms_run_out == aux_run_out) else $error("rms run differs from aux run");
  a_clk_copy: assert property (
    cw |-> ##2 sys_clk_khz_out == $past(hd, 2)) else $error("clock copy wrong");
  a_dsp_cause: assert property (
    dsp_calc_out |-> $past(line_cycle_in)) else $error("dsp start without line cycle");
  a_reserved_zero: assert property (
    ar |=> rvalid_out && rdata_out[15:13] == 3'h0 && !rdata_out[4]) else $error("reserved bits");
  c_dsp: cover property (dsp_calc_out);
  c_aux_wr: cover property (aw ##2 aux_run_out);
  c_slot_wr: cover property (tw);
endmodule : aux_cfg_bank_monitor
bind aux_cfg_bank aux_cfg_bank_monitor i_aux_cfg_bank_monitor (.core_clk_in, .rst_n_in,
  .host_req_in, .fw_req_in, .line_cycle_in, .rdata_out, .rvalid_out, .temp_slot_ctl_out,
  .aux_src_out, .aux_neutral_sub_out, .aux_run_out, .aux_harm_filter_out, .aux_rms_run_out,
  .harm_order_out, .sys_clk_khz_out, .dsp_calc_out);
`default_nettype wire

// ===== testbench/aux_cfg_bank_tb_top.sv
// top testbench for the aux config register bank
`timescale 1ns/1ps
`default_nettype none
module aux_cfg_bank_tb_top;
  import aux_cfg_pkg::*;
  logic core_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic lc = 1'b0;
  reg_req_t hq;
  reg_req_t fq = '0;
  logic [15:0] hv = 16'h1234, hi = 16'hbeef, rdata, sclk, d;
  logic rv, nsub, run, hf, rms, ordv, dsp;
  logic [4:0] ord;
  slot_ctl_t ts;
  aux_src_t src;
  int n_fail = 0, comparisons = 0, ndsp = 0;
  always #2 core_clk_in = ~core_clk_in;
  always @(negedge core_clk_in) if (dsp === 1'b1) ndsp++;
  aux_cfg_bank i_aux_cfg_bank (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
    .host_req_in(hq), .fw_req_in(fq), .line_cycle_in(lc), .harm_v_result_in(hv),
    .harm_i_result_in(hi), .rdata_out(rdata), .rvalid_out(rv), .temp_slot_ctl_out(ts),
    .aux_src_out(src), .aux_neutral_sub_out(nsub), .aux_run_out(run),
    .aux_harm_filter_out(hf), .aux_rms_run_out(rms), .harm_order_out(ord),
    .harm_order_valid_out(ordv), .sys_clk_khz_out(sclk), .dsp_calc_out(dsp));
  host_master_model i_host_master_model (.core_clk_in(core_clk_in), .rvalid_in(rv),
    .rdata_in(rdata), .host_req_out(hq));
  // ------------------------------------------------
  // helpers and scenarios
  // ------------------------------------------------
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic rchk(input logic [11:0] a, input logic [15:0] e);
    i_host_master_model.rd(a, d);
    chk(d, e);
  endtask : rchk
  task automatic fw_wr(input logic [15:0] v);
    @(negedge core_clk_in);
    fq = '{wr: 1'b1, rd: 1'b0, addr: temp_slot_addr, wdata: v};
    @(negedge core_clk_in);
    fq = '{wr: 1'b0, rd: 1'b0, addr: ~temp_slot_addr, wdata: ~v};
    repeat (2) @(negedge core_clk_in);
  endtask : fw_wr
  task automatic t_reset;
    chk({8'h00, ts.temp_sel, ts.skip, ts.gain}, 16'h00c4);
    rchk(temp_slot_addr, 16'h008a);
    rchk(aux_cfg_addr, 16'h0000);
    rchk(sys_clk_addr, 16'h1f40);
    rchk(cyc_cnt_addr, 16'h0010);
    rchk(12'h3ff, 16'h0000);
  endtask : t_reset
  task automatic t_slot;
    logic [7:0] w;
    for (int i = 0; i < 8; i++) begin
      w = {(i[0] ? 4'h7 : 4'hc), i[1], i[2:0]};
      fw_wr({8'h00, w});
      chk({4'h0, ts.analog_sel, ts.temp_sel, ts.auto_zero, ts.skip, ts.gain},
          {4'h0, (i[0] ? 3'h7 : 3'h4), ~i[0], i[0], i[1],
           (i < 6) ? 6'(6'h01 << i) : 6'h00});
      rchk(temp_slot_addr, {8'h00, w});
    end
  endtask : t_slot
  task automatic t_aux;
    logic [3:0] sc [9] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h7, 4'h9, 4'hf};
    aux_src_t es [9] = '{src_none, src_in, src_va, src_none, src_ib, src_vc, src_ic,
                         src_sum3, src_sum4};
    logic [4:0] o;
    logic r;
    for (int k = 0; k < 9; k++) begin
      o = 5'(k * 3);
      r = (es[k] != src_none);
      i_host_master_model.wr(aux_cfg_addr, {3'h0, o, k[0], 1'b1, k[1], 1'b0, sc[k]});
      repeat (2) @(negedge core_clk_in);
      chk({src, run, hf, nsub, rms, ord, ordv, 2'h0}, {es[k], r, r & k[0], sc[k] == 4'hf && k[1],
          r, o, o >= 5'h01 && o <= 5'h15, 2'h0});
    end
    i_host_master_model.wr(aux_cfg_addr, 16'h0089);
    repeat (2) @(negedge core_clk_in);
    chk({13'h0, run, hf, rms}, 16'h0000);
    i_host_master_model.wr(aux_cfg_addr, 16'hffff);
    rchk(aux_cfg_addr, 16'h1fef);
    chk({15'h0, nsub}, 16'h0001);
    rchk(harm_v_addr, 16'h1234);
    rchk(harm_i_addr, 16'hbeef);
    i_host_master_model.wr(sys_clk_addr, 16'h2ee0);
    repeat (2) @(negedge core_clk_in);
    chk(sclk, 16'h2ee0);
  endtask : t_aux
  task automatic pulses(input int n);
    @(negedge core_clk_in);
    lc = 1'b1;
    repeat (n) @(negedge core_clk_in);
    lc = 1'b0;
    repeat (2) @(negedge core_clk_in);
  endtask : pulses
  task automatic t_cycles;
    pulses(15);
    chk(16'(ndsp), 16'h0000);
    pulses(1);
    chk(16'(ndsp), 16'h0001);
    i_host_master_model.wr(cyc_cnt_addr, 16'h0003);
    pulses(3);
    chk(16'(ndsp), 16'h0002);
    pulses(2);
    chk(16'(ndsp), 16'h0002);
  endtask : t_cycles
  task automatic stop_test;
    $display("n_fail %0d comparisons %0d", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : stop_test
  // ------------------------------------------------
  // main sequence and watchdog
  // ------------------------------------------------
  initial begin
    repeat (6) @(negedge core_clk_in);
    rst_n_in = 1'b1;
    repeat (4) @(negedge core_clk_in);
    t_reset();
    t_slot();
    t_aux();
    t_cycles();
    stop_test();
  end
  // generous bound: the sequence needs well under two thousand cycles
  initial begin
    #40000;
    n_fail++;
    stop_test();
  end
endmodule : aux_cfg_bank_tb_top
`default_nettype wire
